// ===== dpram_port_pkg.sv
// Shared constants for the synchronous dual-port RAM port and its APB control.
package dpram_port_pkg;
  // Array shape.
  localparam int ADDR_W_DEF = 13;
  localparam int DATA_W = 18;
  localparam int BYTE_LANES = 2;
  // APB slave shape.
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  // Register byte offsets.
  localparam logic [APB_AW-1:0] CFG_OFF = 12'h000;
  localparam logic [APB_AW-1:0] STAT_OFF = 12'h004;
  // Field positions.
  localparam int CFG_MODE_BIT = 0;
  localparam int STAT_SEL_BIT = 16;
  localparam int STAT_DRV_BIT = 17;
  localparam int STAT_MODE_BIT = 18;
  // Values after reset.
  localparam logic MODE_RST = 1'b1;
  localparam logic [APB_DW-1:0] RDATA_RST = 32'h0000_0000;
endpackage

// ===== dual_port_store.sv
// Two-port word storage with per-byte write enables and combinational reads.
`timescale 1ns/10ps
`default_nettype none
module dual_port_store #(
  parameter int ADDR_W = dpram_port_pkg::ADDR_W_DEF,
  parameter int DATA_W = dpram_port_pkg::DATA_W
) (
  // Clock.
  input wire logic clk,
  // Port A, the documented port.
  input wire logic a_write,
  input wire logic [dpram_port_pkg::BYTE_LANES-1:0] a_byte_en,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire logic [DATA_W-1:0] a_wdata,
  output logic [DATA_W-1:0] a_rdata,
  // Port B, the peer port.
  input wire logic b_write,
  input wire logic [dpram_port_pkg::BYTE_LANES-1:0] b_byte_en,
  input wire logic [ADDR_W-1:0] b_addr,
  input wire logic [DATA_W-1:0] b_wdata,
  output logic [DATA_W-1:0] b_rdata
);
  import dpram_port_pkg::*;

  localparam int LO_W = DATA_W / 2;

  logic [DATA_W-1:0] mem_q [2**ADDR_W];

  // Merge new data into the old word, lane by lane.
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [BYTE_LANES-1:0] be);
    logic [DATA_W-1:0] res;
    res = old_w;
    if (be[0]) res[LO_W-1:0] = new_w[LO_W-1:0];
    if (be[1]) res[DATA_W-1:LO_W] = new_w[DATA_W-1:LO_W];
    return res;
  endfunction

  // Reads see the array as it stands before the coming edge, so a word written
  // by one port is visible to the other from the following cycle on.
  assign a_rdata = mem_q[a_addr];
  assign b_rdata = mem_q[b_addr];

  // The array has no reset, like the storage it models. Port A is applied last
  // so it wins when both ports write one word in the same cycle.
  always_ff @(posedge clk) begin
    if (b_write) begin
      mem_q[b_addr] <= merge(mem_q[b_addr], b_wdata, b_byte_en);
    end
    if (a_write) begin
      mem_q[a_addr] <= merge(mem_q[a_addr], a_wdata, a_byte_en);
    end
  end
endmodule // dual_port_store
`default_nettype wire

// ===== port_host_model.sv
// Host-side model that drives one RAM port and resolves the shared data bus.
`timescale 1ns/10ps
`default_nettype none
module port_host_model #(
  parameter int ADDR_W = dpram_port_pkg::ADDR_W_DEF
) (
  // Clock and the port's own drive.
  input wire logic clk,
  input wire logic [dpram_port_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe_n,
  // Controls, address and the resolved bus level.
  output logic [8:0] ctl,
  output logic [ADDR_W-1:0] address,
  output logic [dpram_port_pkg::DATA_W-1:0] data_in
);
  import dpram_port_pkg::*;
  logic [DATA_W-1:0] d_q;
  logic [DATA_W-1:0] last_q = '0;
  // Start deselected with the counter holding, so nothing moves before the first command.
  initial begin
    ctl = 9'h17E;
    address = '0;
    d_q = '0;
  end
  // Each command changes right after an edge and stands for one whole cycle.
  task automatic op(input logic [8:0] c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    ctl <= c;
    address <= a;
    d_q <= d;
  endtask
  // A released bus shows the inverse of its last level, so stale data never matches by luck.
  assign data_in = !data_oe_n ? data_out : (!ctl[6] ? d_q : ~last_q);
  always @(posedge clk) begin
    last_q <= data_in;
  end
endmodule // port_host_model
`default_nettype wire

// ===== sync_dual_port_ram_port.sv
// One port of a synchronous dual-port RAM with burst counter and APB control.
`timescale 1ns/10ps
`default_nettype none
module sync_dual_port_ram_port #(
  parameter int ADDR_W = dpram_port_pkg::ADDR_W_DEF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dpram_port_pkg::APB_AW-1:0] paddr,
  input wire logic [dpram_port_pkg::APB_DW-1:0] pwdata,
  output logic [dpram_port_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory port controls.
  input wire logic chip_select_active_low,
  input wire logic chip_select_active_high,
  input wire logic read_write_n,
  input wire logic output_enable_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  // Burst counter controls.
  input wire logic address_strobe_load_n,
  input wire logic counter_advance_enable_n,
  input wire logic counter_clear_n,
  // Address and two-way data bus.
  input wire logic [ADDR_W-1:0] address,
  input wire logic [dpram_port_pkg::DATA_W-1:0] data_in,
  output logic [dpram_port_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  // Peer port sharing the array.
  input wire logic peer_write,
  input wire logic [dpram_port_pkg::BYTE_LANES-1:0] peer_byte_en,
  input wire logic [ADDR_W-1:0] peer_address,
  input wire logic [dpram_port_pkg::DATA_W-1:0] peer_wdata,
  output logic [dpram_port_pkg::DATA_W-1:0] peer_rdata
);
  import dpram_port_pkg::*;

  logic mode_q;
  logic [ADDR_W-1:0] cnt_q;
  logic [ADDR_W-1:0] int_addr;
  logic selected;
  logic wr_fire;
  logic rd_fire;
  logic [BYTE_LANES-1:0] byte_en;
  logic [DATA_W-1:0] rd_data_a;
  logic [DATA_W-1:0] rd_data_b;
  logic [DATA_W-1:0] ft_data_q;
  logic ft_drive_q;
  logic [DATA_W-1:0] dout_q;
  logic drive_q;
  logic sel_q;
  logic [DATA_W-1:0] peer_rdata_q;
  logic [APB_DW-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic apb_setup;
  logic apb_done;

  // Tells whether an APB address hits one of the registers.
  function automatic logic reg_hit(input logic [APB_AW-1:0] a);
    return (a == CFG_OFF) || (a == STAT_OFF);
  endfunction

  // Read value of a register; unmapped addresses read as zero.
  function automatic logic [APB_DW-1:0] reg_read(input logic [APB_AW-1:0] a,
                                                 input logic mode,
                                                 input logic [ADDR_W-1:0] cnt,
                                                 input logic sel,
                                                 input logic drv);
    logic [APB_DW-1:0] v;
    v = '0;
    if (a == CFG_OFF) begin
      v[CFG_MODE_BIT] = mode;
    end else if (a == STAT_OFF) begin
      v[ADDR_W-1:0] = cnt;
      v[STAT_SEL_BIT] = sel;
      v[STAT_DRV_BIT] = drv;
      v[STAT_MODE_BIT] = mode;
    end
    return v;
  endfunction

  // Port decode. All these pins are synchronous to clk and are only acted on
  // at the rising edge, so they need no synchroniser.
  assign selected = !chip_select_active_low && chip_select_active_high;
  assign wr_fire = selected && !read_write_n;
  assign rd_fire = selected && read_write_n;
  assign byte_en = {!upper_byte_select_n, !lower_byte_select_n};

  // Internal access address. Clear overrides strobe and advance enable, and
  // the clearing cycle itself accesses word zero, so no cycle is wasted.
  always_comb begin
    if (!counter_clear_n) begin
      int_addr = '0;
    end else if (!address_strobe_load_n) begin
      int_addr = address;
    end else if (!counter_advance_enable_n) begin
      int_addr = cnt_q + ADDR_W'(1);
    end else begin
      int_addr = cnt_q;
    end
  end

  // Burst counter keeps the last internal address; chip selects are ignored
  // on purpose so a deselected port can still be steered for the next burst.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= int_addr;
    end
  end

  // Shared array; this port writes at the edge that samples the request.
  dual_port_store #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_store (
    .clk(clk),
    .a_write(wr_fire),
    .a_byte_en(byte_en),
    .a_addr(int_addr),
    .a_wdata(data_in),
    .a_rdata(rd_data_a),
    .b_write(peer_write),
    .b_byte_en(peer_byte_en),
    .b_addr(peer_address),
    .b_wdata(peer_wdata),
    .b_rdata(rd_data_b)
  );

  // Read path. The first stage always captures the word; the output register
  // takes either the array directly (flow-through) or the first stage
  // (pipelined), which costs one cycle but shortens the array-to-pin path.
  always_ff @(posedge clk) begin
    if (rst) begin
      ft_data_q <= '0;
      ft_drive_q <= 1'b0;
      dout_q <= '0;
      drive_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      ft_data_q <= rd_data_a;
      ft_drive_q <= rd_fire;
      sel_q <= selected;
      if (mode_q) begin
        dout_q <= ft_data_q;
        drive_q <= ft_drive_q;
      end else begin
        dout_q <= rd_data_a;
        drive_q <= rd_fire;
      end
    end
  end

  // The output enable gates the drivers with no clock in the path, so the
  // bus floats the moment it rises. This is the one output not from a flop.
  assign data_oe_n = !drive_q || output_enable_n;
  assign data_out = dout_q;

  // Peer read data is registered so the peer sees it one cycle after asking.
  always_ff @(posedge clk) begin
    if (rst) begin
      peer_rdata_q <= '0;
    end else begin
      peer_rdata_q <= rd_data_b;
    end
  end
  assign peer_rdata = peer_rdata_q;

  // APB phases: the answer is prepared at the setup edge, so every access
  // phase completes in exactly one cycle.
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && pready_q;

  // APB handshake and read data.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RDATA_RST;
    end else if (apb_setup) begin
      pready_q <= 1'b1;
      pslverr_q <= !reg_hit(paddr);
      prdata_q <= pwrite ? RDATA_RST : reg_read(paddr, mode_q, cnt_q, sel_q, drive_q);
    end else if (apb_done) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RDATA_RST;
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // Output mode register. Changing it while reads are in flight may repeat or
  // drop one word on the bus, so software should switch it while idle.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= MODE_RST;
    end else if (apb_done && pwrite && paddr == CFG_OFF) begin
      mode_q <= pwdata[CFG_MODE_BIT];
    end
  end

  // Checks on the port's behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_clear_to_zero: assert property (
    !counter_clear_n |=> cnt_q == '0)
    else $error("Counter clear did not give address zero.");

  a_load_external: assert property (
    counter_clear_n && !address_strobe_load_n |=> cnt_q == $past(address))
    else $error("Address strobe did not load the external address.");

  a_hold_counter: assert property (
    counter_clear_n && address_strobe_load_n && counter_advance_enable_n
    |=> $stable(cnt_q))
    else $error("Counter moved while held.");

  a_incr_counter: assert property (
    counter_clear_n && address_strobe_load_n && !counter_advance_enable_n
    |=> cnt_q == ADDR_W'($past(cnt_q) + ADDR_W'(1)))
    else $error("Counter did not advance by one.");

  a_flow_deselect: assert property (
    !mode_q && !selected |=> data_oe_n)
    else $error("Flow-through port drove the bus after deselection.");

  a_pipe_deselect: assert property (
    (mode_q && !selected) ##1 mode_q |=> data_oe_n)
    else $error("Pipelined port drove the bus after deselection.");

  a_oe_float: assert property (
    output_enable_n |-> data_oe_n)
    else $error("Bus driven while output enable is high.");

  a_flow_read: assert property (
    (wr_fire && byte_en == 2'h3 && !mode_q)
    ##1 (rd_fire && !mode_q && int_addr == $past(int_addr))
    |=> !data_oe_n || output_enable_n ##0 data_out == $past(data_in, 2))
    else $error("Read after write returned the wrong word.");

  a_pipe_latency: assert property (
    (rd_fire && mode_q) ##1 mode_q |=> drive_q && data_out == $past(rd_data_a, 2))
    else $error("Pipelined read data not two edges after sampling.");

  a_apb_ready: assert property (
    apb_setup |=> pready ##1 !pready)
    else $error("APB answer not given in the access phase.");

  c_pipe_read: cover property (rd_fire && mode_q ##2 !data_oe_n);
  c_clear_write: cover property (!counter_clear_n && wr_fire);
  c_counter_wrap: cover property (
    counter_clear_n && address_strobe_load_n && !counter_advance_enable_n && cnt_q == '1);
  c_cfg_write: cover property (apb_done && pwrite && paddr == CFG_OFF);
endmodule // sync_dual_port_ram_port
`default_nettype wire

// ===== sync_dual_port_ram_port_test.sv
// Self-checking bench for the RAM port: register reads first, then a row table, then the awkward cases.
`timescale 1ns/10ps
`default_nettype none
module sync_dual_port_ram_port_test;
  import dpram_port_pkg::*;
  // Control bits: select low, select high, read, upper, lower, strobe, advance, clear, oe.
  localparam logic [8:0] RD = 9'h0F6;
  localparam logic [8:0] RINC = 9'h0FA;
  localparam logic [8:0] RHOLD = 9'h0FE;
  localparam logic [8:0] RCLR = 9'h0F0;
  localparam logic [8:0] WR = 9'h086;
  localparam logic [8:0] IDLE = 9'h17E;
  typedef struct packed {logic [12:0] a; logic [17:0] d; logic [1:0] be_n; logic m;
    logic [17:0] e;} row_s;
  row_s rows [5] = '{'{13'h0005, 18'h3FFFF, 2'h0, 1'h0, 18'h3FFFF},
    '{13'h0005, 18'h00000, 2'h2, 1'h1, 18'h3FE00}, '{13'h1FFF, 18'h2AAAA, 2'h0, 1'h0, 18'h2AAAA},
    '{13'h1FFF, 18'h15555, 2'h1, 1'h1, 18'h154AA}, '{13'h0000, 18'h12345, 2'h0, 1'h0, 18'h12345}};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0;
  logic [APB_DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [8:0] ctl;
  logic [12:0] address;
  logic [DATA_W-1:0] data_in;
  logic [DATA_W-1:0] data_out;
  logic data_oe_n;
  logic peer_write = 1'h0;
  logic [BYTE_LANES-1:0] peer_byte_en = 2'h3;
  logic [12:0] peer_address = '0;
  logic [DATA_W-1:0] peer_wdata = '0;
  logic [DATA_W-1:0] peer_rdata;
  int n_fail = 0;
  int compares = 0;
  // Device and the host model on its memory side.
  sync_dual_port_ram_port i_sync_dual_port_ram_port (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_active_low(ctl[8]), .chip_select_active_high(ctl[7]), .read_write_n(ctl[6]),
    .upper_byte_select_n(ctl[5]), .lower_byte_select_n(ctl[4]), .address_strobe_load_n(ctl[3]),
    .counter_advance_enable_n(ctl[2]), .counter_clear_n(ctl[1]), .output_enable_n(ctl[0]),
    .address(address), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .peer_write(peer_write), .peer_byte_en(peer_byte_en), .peer_address(peer_address),
    .peer_wdata(peer_wdata), .peer_rdata(peer_rdata)
  );
  port_host_model host (
    .clk(clk), .data_out(data_out), .data_oe_n(data_oe_n),
    .ctl(ctl), .address(address), .data_in(data_in)
  );
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // The request stands until pready is seen high at an edge; data is taken at that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic pw(input logic [12:0] a, input logic [17:0] d);
    @(posedge clk);
    peer_write <= 1'h1;
    peer_address <= a;
    peer_wdata <= d;
    @(posedge clk);
    peer_write <= 1'h0;
  endtask
  task automatic settle(input logic e);
    host.op(IDLE, 13'h0, 18'h0);
    #1;
    chk("data_oe_n", 32'(e), 32'(data_oe_n));
  endtask
  task automatic step(input logic [8:0] c, input logic [12:0] a, input logic [17:0] e);
    host.op(c, a, 18'h0);
    settle(1'h0);
    chk("data_out", 32'(e), 32'(data_out));
  endtask
  // Main sequence.
  initial begin
    logic [31:0] rd;
    logic err;
    logic [8:0] ds;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, CFG_OFF, 32'h0, rd, err);
    chk("cfg", 32'(MODE_RST), rd);
    apb(1'h0, STAT_OFF, 32'h0, rd, err);
    chk("status", 32'h1 << STAT_MODE_BIT, rd);
    apb(1'h0, 12'h008, 32'h0, rd, err);
    chk("pslverr", 32'h1, 32'(err));
    chk("prdata", 32'h0, rd);
    // Write a row, read it back on both ports, then watch the bus let go.
    foreach (rows[i]) begin
      apb(1'h1, CFG_OFF, 32'(rows[i].m), rd, err);
      host.op(WR | {3'h0, rows[i].be_n, 4'h0}, rows[i].a, rows[i].d);
      peer_address <= rows[i].a;
      host.op(RD, rows[i].a, 18'h0);
      settle(rows[i].m);
      chk("peer_rdata", 32'(rows[i].e), 32'(peer_rdata));
      if (rows[i].m) settle(1'h0);
      chk("data_out", 32'(rows[i].e), 32'(data_out));
      settle(1'h1);
    end
    // Counter walk in flow mode: load, advance across the top, hold, clear.
    pw(13'h1FFE, 18'h3C3C3);
    pw(13'h0001, 18'h0ABCD);
    step(RD, 13'h1FFE, 18'h3C3C3);
    step(RINC, 13'h0, 18'h154AA);
    step(RINC, 13'h0, 18'h12345);
    step(RHOLD, 13'h1FFE, 18'h12345);
    host.op(RINC ^ 9'h100, 13'h0, 18'h0);
    settle(1'h1);
    step(RHOLD, 13'h0, 18'h0ABCD);
    step(RCLR, 13'h1FFE, 18'h12345);
    host.op(WR & 9'h1FD, 13'h1FFF, 18'h00F0F);
    step(RHOLD, 13'h1FFF, 18'h00F0F);
    // Either inactive select blocks the write and the drive alike.
    for (int k = 0; k < 2; k++) begin
      ds = k ? 9'h080 : 9'h100;
      host.op(WR ^ ds, 13'h0005, 18'h0);
      host.op(RD ^ ds, 13'h0005, 18'h0);
      settle(1'h1);
      step(RD, 13'h0005, 18'h3FE00);
    end
    host.op(WR, 13'h0005, 18'h3FE00);
    // Output enable gates a steady read between edges, not at them.
    host.op(RD, 13'h0005, 18'h0);
    host.op(RHOLD, 13'h0, 18'h0);
    host.op(RHOLD ^ 9'h001, 13'h0, 18'h0);
    #1;
    chk("oe_off", 32'h1, 32'(data_oe_n));
    host.op(RHOLD, 13'h0, 18'h0);
    #1;
    chk("oe_on", 32'h0, 32'(data_oe_n));
    // Pipelined: a deselect reaches the bus one cycle late.
    apb(1'h1, CFG_OFF, 32'h1, rd, err);
    host.op(RHOLD ^ 9'h100, 13'h0, 18'h0);
    settle(1'h0);
    settle(1'h1);
    // A reset in mid-read releases the bus and restores pipelined mode.
    apb(1'h1, CFG_OFF, 32'h0, rd, err);
    host.op(RD, 13'h0005, 18'h0);
    // Park the counter on hold so no load is still pending when reset lets go.
    host.op(IDLE, 13'h0, 18'h0);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk("oe_reset", 32'h1, 32'(data_oe_n));
    apb(1'h0, CFG_OFF, 32'h0, rd, err);
    chk("cfg_reset", 32'(MODE_RST), rd);
    summarize();
  end
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule // sync_dual_port_ram_port_test
`default_nettype wire
